/* File: design/path_cfg_pkg.sv */
/*
  Constants shared by the path configuration register bank.
  Assumes an 8-bit register port with byte offsets in a 7-bit address space.
*/
package path_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_AUX_FREQ = 7'h64;
  localparam logic [6:0] ADDR_MAIN_FREQ = 7'h65;
  localparam logic [6:0] ADDR_AUX_BW = 7'h66;
  localparam logic [6:0] ADDR_MAIN_LOCKED_BW = 7'h67;
  localparam logic [6:0] ADDR_MAIN_ACQ_BW = 7'h69;
  localparam logic [6:0] ADDR_AUX_DAMP = 7'h6A;
  localparam logic [6:0] ADDR_MAIN_DAMP = 7'h6B;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_AUX_FREQ = 8'h01;
  localparam logic [7:0] RST_MAIN_FREQ = 8'h00;
  localparam logic [7:0] RST_AUX_BW = 8'h00;
  localparam logic [7:0] RST_MAIN_LOCKED_BW = 8'h0B;
  localparam logic [7:0] RST_MAIN_ACQ_BW = 8'h0F;
  localparam logic [7:0] RST_AUX_DAMP = 8'h13;
  localparam logic [7:0] RST_MAIN_DAMP = 8'h13;

  // ----------------------------------------------------------------
  // Writable masks (unused bits read zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_AUX_FREQ = 8'h77;
  localparam logic [7:0] MASK_MAIN_FREQ = 8'hF7;
  localparam logic [7:0] MASK_AUX_BW = 8'h03;
  localparam logic [7:0] MASK_BW5 = 8'h1F;
  localparam logic [7:0] MASK_DAMP = 8'h77;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUX_SQUELCH_BIT = 6;
  localparam int DUTY_BIT = 5;
  localparam int BITS_STD_BIT = 4;
  localparam int MEASURE_BIT = 7;
  localparam int APLL_SRC_BIT = 6;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] AUX_RATE_OFF = 3'h0;
  localparam logic [2:0] MAIN_RATE_ANALOG = 3'h1;
  localparam logic [2:0] MAIN_RATE_LAST = 3'h5;
  localparam logic [1:0] AUX_BW_UNUSED = 2'h3;
  localparam logic [4:0] BW5_LAST = 5'h11;
  localparam logic [2:0] DAMP_FIRST = 3'h1;
  localparam logic [2:0] DAMP_LAST = 3'h5;

  // Generated rate selections seen by the synthesisers
  typedef enum logic [3:0] {
    RATE_OFF, RATE_OCN, RATE_12E1, RATE_16E1, RATE_24DS1, RATE_16DS1,
    RATE_E3, RATE_DS3, RATE_NONE
  } rate_e;

endpackage

/* File: design/path_cfg_if.sv */
/*
  Register write strobe bundle passed from the bank to the code checker.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
interface path_cfg_if;
  logic [6:0] addr;
  logic [7:0] data;
  logic legal;
  modport bank (output addr, output data, input legal);
  modport check (input addr, input data, output legal);
endinterface

/* File: design/path_code_check.sv */
/*
  Judges whether a written code uses only defined field values.
  Assumes a combinational answer is taken in the same cycle as the write.
*/
`timescale 1ns/1ps
module path_code_check (
  path_cfg_if.check wr
);

  // ----------------------------------------------------------------
  // Field legality per register
  // ----------------------------------------------------------------
  function automatic logic damp_ok(input logic [2:0] c);
    damp_ok = (c >= path_cfg_pkg::DAMP_FIRST) && (c <= path_cfg_pkg::DAMP_LAST);
  endfunction

  // Unused codes are flagged, not blocked
  always_comb begin
    case (wr.addr)
      path_cfg_pkg::ADDR_MAIN_FREQ: wr.legal = wr.data[2:0] <= path_cfg_pkg::MAIN_RATE_LAST;
      path_cfg_pkg::ADDR_AUX_BW: wr.legal = wr.data[1:0] != path_cfg_pkg::AUX_BW_UNUSED;
      path_cfg_pkg::ADDR_MAIN_LOCKED_BW,
      path_cfg_pkg::ADDR_MAIN_ACQ_BW: wr.legal = wr.data[4:0] <= path_cfg_pkg::BW5_LAST;
      path_cfg_pkg::ADDR_AUX_DAMP,
      path_cfg_pkg::ADDR_MAIN_DAMP: wr.legal = damp_ok(wr.data[2:0]);
      default: wr.legal = 1'b1;
    endcase
  end

endmodule

/* File: design/path_cfg_regs.sv */
/*
  Configuration register bank for the main and auxiliary timing paths.
  Assumes an 8-bit microprocessor port synchronous to CLOCK; status inputs
  from the loops and the standard pin arrive asynchronously.
*/
// Contract
// - Aux input fail squelches composite and BITS
// - Duty bit picks 50:50 or 5:8
// - BITS standard bit: 0 SDH, 1 SONET
// - BITS bit obeyed only when global select clear
// - BITS bit resets from standard pin
// - Aux rate code 000 squelches aux loop
// - Aux rate codes map to synth rates
// - Phase measure disables aux loop
// - Aux synth source: aux or main loop
// - Main-fed aux synth rate from 2-bit field
// - Aux bandwidth 18/35/70 Hz, 11 unused
// - Main bandwidth fields share 18-step code
// - Aux damping codes 001-101, others unused
// - Damping fields reset to code 011
// - Low-rate analog gain field stored
// - Main damping codes 001-101, others unused
`timescale 1ns/1ps
module path_cfg_regs (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic BAD_CODE,
  input wire logic STANDARD_SELECT_PIN,
  input wire logic GLOBAL_SONET,
  input wire logic GLOBAL_OVERRIDE,
  input wire logic AUX_INPUTS_FAILED,
  input wire logic MAIN_PHASE_LOCKED,
  input wire logic BW_AUTO_SWITCH,
  input wire logic COMPOSITE_ENABLE,
  input wire logic BITS_ENABLE,
  output logic COMPOSITE_CLOCK_OUTPUT_EN,
  output logic BITS_CLOCK_OUTPUT_EN,
  output logic COMPOSITE_DUTY_5_8,
  output logic BITS_SONET,
  output logic AUX_DPLL_RUN,
  output logic AUX_PHASE_MEASURE,
  output logic AUX_APLL_FROM_MAIN,
  output logic [3:0] AUX_APLL_RATE,
  output logic [3:0] MAIN_APLL_RATE,
  output logic MAIN_ANALOG_FEEDBACK,
  output logic [1:0] AUX_BANDWIDTH,
  output logic [4:0] MAIN_BANDWIDTH,
  output logic [2:0] AUX_DAMPING,
  output logic [2:0] MAIN_DAMPING,
  output logic [2:0] AUX_LOWRATE_GAIN,
  output logic [2:0] MAIN_LOWRATE_GAIN
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic pin_q, global_sonet_q, override_q, aux_fail_q, locked_q, auto_q, comp_en_q, bits_en_q;
  logic strap_pending_q;

  // Two flops on each asynchronous level, all pins in one group
  always_ff @(posedge CLOCK) begin
    meta_q <= {STANDARD_SELECT_PIN, GLOBAL_SONET, GLOBAL_OVERRIDE, AUX_INPUTS_FAILED,
               MAIN_PHASE_LOCKED, BW_AUTO_SWITCH, COMPOSITE_ENABLE, BITS_ENABLE};
    sync_q <= meta_q;
  end

  // Names for the synchronised levels
  assign pin_q = sync_q[7];
  assign global_sonet_q = sync_q[6];
  assign override_q = sync_q[5];
  assign aux_fail_q = sync_q[4];
  assign locked_q = sync_q[3];
  assign auto_q = sync_q[2];
  assign comp_en_q = sync_q[1];
  assign bits_en_q = sync_q[0];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] aux_freq_q;
  logic [7:0] main_freq_q;
  logic [7:0] aux_bw_q;
  logic [7:0] main_locked_bw_q;
  logic [7:0] main_acq_bw_q;
  logic [7:0] aux_damp_q;
  logic [7:0] main_damp_q;

  path_cfg_if wr_if ();

  assign wr_if.addr = ADDR;
  assign wr_if.data = WDATA;

  path_code_check u_check (
    .wr(wr_if)
  );

  // Strap catch waits until the pin has crossed both flops
  logic [1:0] strap_cnt_q;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      strap_cnt_q <= 2'h0;
      strap_pending_q <= 1'b1;
    end else if (strap_pending_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        strap_pending_q <= 1'b0;
      end
    end
  end

  // Aux path frequency register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      aux_freq_q <= path_cfg_pkg::RST_AUX_FREQ;
    end else if (WRITE && ADDR == path_cfg_pkg::ADDR_AUX_FREQ) begin
      aux_freq_q <= WDATA & path_cfg_pkg::MASK_AUX_FREQ;
    end else if (strap_pending_q && strap_cnt_q == 2'h2) begin
      aux_freq_q[path_cfg_pkg::BITS_STD_BIT] <= pin_q;
    end
  end

  // Main path frequency register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      main_freq_q <= path_cfg_pkg::RST_MAIN_FREQ;
    end else if (WRITE && ADDR == path_cfg_pkg::ADDR_MAIN_FREQ) begin
      main_freq_q <= WDATA & path_cfg_pkg::MASK_MAIN_FREQ;
    end
  end

  // Bandwidth registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      aux_bw_q <= path_cfg_pkg::RST_AUX_BW;
      main_locked_bw_q <= path_cfg_pkg::RST_MAIN_LOCKED_BW;
      main_acq_bw_q <= path_cfg_pkg::RST_MAIN_ACQ_BW;
    end else if (WRITE) begin
      if (ADDR == path_cfg_pkg::ADDR_AUX_BW) begin
        aux_bw_q <= WDATA & path_cfg_pkg::MASK_AUX_BW;
      end
      if (ADDR == path_cfg_pkg::ADDR_MAIN_LOCKED_BW) begin
        main_locked_bw_q <= WDATA & path_cfg_pkg::MASK_BW5;
      end
      if (ADDR == path_cfg_pkg::ADDR_MAIN_ACQ_BW) begin
        main_acq_bw_q <= WDATA & path_cfg_pkg::MASK_BW5;
      end
    end
  end

  // Damping and low-rate gain registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      aux_damp_q <= path_cfg_pkg::RST_AUX_DAMP;
      main_damp_q <= path_cfg_pkg::RST_MAIN_DAMP;
    end else if (WRITE) begin
      if (ADDR == path_cfg_pkg::ADDR_AUX_DAMP) begin
        aux_damp_q <= WDATA & path_cfg_pkg::MASK_DAMP;
      end
      if (ADDR == path_cfg_pkg::ADDR_MAIN_DAMP) begin
        main_damp_q <= WDATA & path_cfg_pkg::MASK_DAMP;
      end
    end
  end

  // Sticky flag for a write that used an unused code; a read of the main frequency offset clears it
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      BAD_CODE <= 1'b0;
    end else if (WRITE && !wr_if.legal) begin
      BAD_CODE <= 1'b1;
    end else if (READ && ADDR == path_cfg_pkg::ADDR_MAIN_FREQ) begin
      BAD_CODE <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // One-cycle registered read; unmapped offsets read zero
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else begin
      RVALID <= READ;
      if (READ) begin
        case (ADDR)
          path_cfg_pkg::ADDR_AUX_FREQ: RDATA <= aux_freq_q;
          path_cfg_pkg::ADDR_MAIN_FREQ: RDATA <= main_freq_q;
          path_cfg_pkg::ADDR_AUX_BW: RDATA <= aux_bw_q;
          path_cfg_pkg::ADDR_MAIN_LOCKED_BW: RDATA <= main_locked_bw_q;
          path_cfg_pkg::ADDR_MAIN_ACQ_BW: RDATA <= main_acq_bw_q;
          path_cfg_pkg::ADDR_AUX_DAMP: RDATA <= aux_damp_q;
          path_cfg_pkg::ADDR_MAIN_DAMP: RDATA <= main_damp_q;
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Rate decoding
  // ----------------------------------------------------------------
  function automatic path_cfg_pkg::rate_e aux_rate(input logic [2:0] c);
    case (c)
      3'h0: aux_rate = path_cfg_pkg::RATE_OFF;
      3'h1: aux_rate = path_cfg_pkg::RATE_OCN;
      3'h2: aux_rate = path_cfg_pkg::RATE_12E1;
      3'h3: aux_rate = path_cfg_pkg::RATE_16E1;
      3'h4: aux_rate = path_cfg_pkg::RATE_24DS1;
      3'h5: aux_rate = path_cfg_pkg::RATE_16DS1;
      3'h6: aux_rate = path_cfg_pkg::RATE_E3;
      default: aux_rate = path_cfg_pkg::RATE_DS3;
    endcase
  endfunction

  function automatic path_cfg_pkg::rate_e main_rate(input logic [2:0] c);
    case (c)
      3'h0, 3'h1: main_rate = path_cfg_pkg::RATE_OCN;
      3'h2: main_rate = path_cfg_pkg::RATE_12E1;
      3'h3: main_rate = path_cfg_pkg::RATE_16E1;
      3'h4: main_rate = path_cfg_pkg::RATE_24DS1;
      3'h5: main_rate = path_cfg_pkg::RATE_16DS1;
      default: main_rate = path_cfg_pkg::RATE_NONE;
    endcase
  endfunction

  logic measure;
  logic from_main;
  logic aux_run;
  assign measure = main_freq_q[path_cfg_pkg::MEASURE_BIT];
  assign from_main = main_freq_q[path_cfg_pkg::APLL_SRC_BIT];
  assign aux_run = (aux_freq_q[2:0] != path_cfg_pkg::AUX_RATE_OFF) && !measure;

  // Aux path controls
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      AUX_DPLL_RUN <= 1'b0;
      AUX_PHASE_MEASURE <= 1'b0;
      AUX_APLL_FROM_MAIN <= 1'b0;
      AUX_APLL_RATE <= path_cfg_pkg::RATE_OFF;
    end else begin
      AUX_DPLL_RUN <= aux_run;
      AUX_PHASE_MEASURE <= measure;
      AUX_APLL_FROM_MAIN <= from_main;
      if (from_main) begin
        AUX_APLL_RATE <= main_rate({1'b0, main_freq_q[5:4]} + 3'h2);
      end else begin
        AUX_APLL_RATE <= aux_rate(aux_freq_q[2:0]);
      end
    end
  end

  // Main path rate and feedback
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      MAIN_APLL_RATE <= path_cfg_pkg::RATE_OCN;
      MAIN_ANALOG_FEEDBACK <= 1'b0;
    end else begin
      MAIN_APLL_RATE <= main_rate(main_freq_q[2:0]);
      MAIN_ANALOG_FEEDBACK <= main_freq_q[2:0] == path_cfg_pkg::MAIN_RATE_ANALOG;
    end
  end

  // Loop filter settings
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      AUX_BANDWIDTH <= path_cfg_pkg::RST_AUX_BW[1:0];
      MAIN_BANDWIDTH <= path_cfg_pkg::RST_MAIN_LOCKED_BW[4:0];
      AUX_DAMPING <= path_cfg_pkg::RST_AUX_DAMP[2:0];
      MAIN_DAMPING <= path_cfg_pkg::RST_MAIN_DAMP[2:0];
      AUX_LOWRATE_GAIN <= path_cfg_pkg::RST_AUX_DAMP[6:4];
      MAIN_LOWRATE_GAIN <= path_cfg_pkg::RST_MAIN_DAMP[6:4];
    end else begin
      AUX_BANDWIDTH <= aux_bw_q[1:0];
      MAIN_BANDWIDTH <= (auto_q && !locked_q) ? main_acq_bw_q[4:0] : main_locked_bw_q[4:0];
      AUX_DAMPING <= aux_damp_q[2:0];
      MAIN_DAMPING <= main_damp_q[2:0];
      AUX_LOWRATE_GAIN <= aux_damp_q[6:4];
      MAIN_LOWRATE_GAIN <= main_damp_q[6:4];
    end
  end

  // ----------------------------------------------------------------
  // Output stage controls
  // ----------------------------------------------------------------
  logic squelch;
  assign squelch = aux_freq_q[path_cfg_pkg::AUX_SQUELCH_BIT] && aux_fail_q;

  // Registered enables, duty and standard select for the output stage
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      COMPOSITE_CLOCK_OUTPUT_EN <= 1'b0;
      BITS_CLOCK_OUTPUT_EN <= 1'b0;
      COMPOSITE_DUTY_5_8 <= 1'b0;
      BITS_SONET <= 1'b0;
    end else begin
      COMPOSITE_CLOCK_OUTPUT_EN <= comp_en_q && !squelch;
      BITS_CLOCK_OUTPUT_EN <= bits_en_q && !squelch;
      COMPOSITE_DUTY_5_8 <= aux_freq_q[path_cfg_pkg::DUTY_BIT];
      BITS_SONET <= override_q ? global_sonet_q : aux_freq_q[path_cfg_pkg::BITS_STD_BIT];
    end
  end

endmodule

/* File: test/path_cfg_regs_sva.sv */
/*
  Port-level checks on the path configuration register bank.
  Assumes one CLOCK domain with a synchronous active-high RESET.
*/
`timescale 1ns/1ps
module path_cfg_regs_sva (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic GLOBAL_SONET,
  input wire logic GLOBAL_OVERRIDE,
  input wire logic COMPOSITE_ENABLE,
  input wire logic BAD_CODE,
  input wire logic COMPOSITE_CLOCK_OUTPUT_EN,
  input wire logic COMPOSITE_DUTY_5_8,
  input wire logic BITS_SONET,
  input wire logic AUX_DPLL_RUN,
  input wire logic AUX_PHASE_MEASURE,
  input wire logic MAIN_ANALOG_FEEDBACK,
  input wire logic [2:0] AUX_DAMPING,
  input wire logic [2:0] MAIN_DAMPING
);
  // ----------------------------------------------------------------
  // Clocking and write sequence
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // Write strobe at one offset
  sequence s_wr(logic [6:0] a);
    WRITE && ADDR == a;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Written fields reach the outputs two edges later; damping outputs read code 011 after reset
  property p_duty;
    s_wr(path_cfg_pkg::ADDR_AUX_FREQ) |-> ##2 COMPOSITE_DUTY_5_8 == $past(WDATA[5], 2);
  endproperty
  a_duty: assert property (p_duty) else $error("duty output wrong");
  property p_aux_off;
    s_wr(path_cfg_pkg::ADDR_AUX_FREQ) ##0 WDATA[2:0] == 3'h0 |-> ##2 !AUX_DPLL_RUN;
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux loop not squelched");
  property p_measure;
    s_wr(path_cfg_pkg::ADDR_MAIN_FREQ) ##0 WDATA[7] |-> ##2 AUX_PHASE_MEASURE && !AUX_DPLL_RUN;
  endproperty
  a_measure: assert property (p_measure) else $error("measure mode wrong");
  property p_analog;
    s_wr(path_cfg_pkg::ADDR_MAIN_FREQ) ##0 WDATA[2:0] == 3'h1 |-> ##2 MAIN_ANALOG_FEEDBACK;
  endproperty
  a_analog: assert property (p_analog) else $error("analog feedback missing");
  property p_aux_damp;
    s_wr(path_cfg_pkg::ADDR_AUX_DAMP) |-> ##2 AUX_DAMPING == $past(WDATA[2:0], 2);
  endproperty
  a_aux_damp: assert property (p_aux_damp) else $error("aux damping wrong");
  property p_main_damp;
    s_wr(path_cfg_pkg::ADDR_MAIN_DAMP) |-> ##2 MAIN_DAMPING == $past(WDATA[2:0], 2);
  endproperty
  a_main_damp: assert property (p_main_damp) else $error("main damping wrong");
  property p_reset_damp;
    $fell(RESET) |-> AUX_DAMPING == 3'h3 && MAIN_DAMPING == 3'h3;
  endproperty
  a_reset_damp: assert property (p_reset_damp) else $error("damping reset wrong");
  // Settled pin levels propagate to the outputs; an unused aux bandwidth code sets BAD_CODE
  property p_sonet;
    (GLOBAL_OVERRIDE && $stable(GLOBAL_SONET)) [*5] |=> BITS_SONET == $past(GLOBAL_SONET);
  endproperty
  a_sonet: assert property (p_sonet) else $error("global standard ignored");
  property p_en_off;
    !COMPOSITE_ENABLE [*5] |=> !COMPOSITE_CLOCK_OUTPUT_EN;
  endproperty
  a_en_off: assert property (p_en_off) else $error("composite enabled");
  property p_bad_bw;
    s_wr(path_cfg_pkg::ADDR_AUX_BW) ##0 WDATA[1:0] == 2'h3 |-> ##[1:2] BAD_CODE;
  endproperty
  a_bad_bw: assert property (p_bad_bw) else $error("unused code not flagged");
endmodule

bind path_cfg_regs path_cfg_regs_sva path_cfg_regs_sva_inst (.*);

/* File: test/tb.sv */
/*
  Self-checking bench for the path configuration register bank.
  Assumes the package, interface and design modules are compiled first.
*/
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic [6:0] ADDR = 7'h00;
  logic [7:0] WDATA = 8'h00;
  logic WRITE = 1'b0;
  logic READ = 1'b0;
  logic [7:0] pins = 8'h01;
  logic [7:0] RDATA, v;
  logic RVALID, BAD_CODE, COMPOSITE_CLOCK_OUTPUT_EN, BITS_CLOCK_OUTPUT_EN, COMPOSITE_DUTY_5_8;
  logic BITS_SONET, AUX_DPLL_RUN, AUX_PHASE_MEASURE, AUX_APLL_FROM_MAIN, MAIN_ANALOG_FEEDBACK;
  logic [3:0] AUX_APLL_RATE, MAIN_APLL_RATE;
  logic [1:0] AUX_BANDWIDTH;
  logic [4:0] MAIN_BANDWIDTH;
  logic [2:0] AUX_DAMPING, MAIN_DAMPING, AUX_LOWRATE_GAIN, MAIN_LOWRATE_GAIN;
  logic [31:0] r;
  integer seed;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] mdl [8];
  logic [6:0] adr [8] = '{path_cfg_pkg::ADDR_AUX_FREQ, path_cfg_pkg::ADDR_MAIN_FREQ,
    path_cfg_pkg::ADDR_AUX_BW, path_cfg_pkg::ADDR_MAIN_LOCKED_BW, path_cfg_pkg::ADDR_MAIN_ACQ_BW,
    path_cfg_pkg::ADDR_AUX_DAMP, path_cfg_pkg::ADDR_MAIN_DAMP, 7'h68};
  logic [7:0] msk [8] = '{path_cfg_pkg::MASK_AUX_FREQ, path_cfg_pkg::MASK_MAIN_FREQ,
    path_cfg_pkg::MASK_AUX_BW, path_cfg_pkg::MASK_BW5, path_cfg_pkg::MASK_BW5,
    path_cfg_pkg::MASK_DAMP, path_cfg_pkg::MASK_DAMP, 8'h00};
  logic [7:0] rst [8] = '{path_cfg_pkg::RST_AUX_FREQ, path_cfg_pkg::RST_MAIN_FREQ,
    path_cfg_pkg::RST_AUX_BW, path_cfg_pkg::RST_MAIN_LOCKED_BW, path_cfg_pkg::RST_MAIN_ACQ_BW,
    path_cfg_pkg::RST_AUX_DAMP, path_cfg_pkg::RST_MAIN_DAMP, 8'h00};
  // Unused-code table: index, data, expected flag
  logic [15:0] bad [8] = '{16'h2031, 16'h3110, 16'h3121, 16'h41F1, 16'h5001, 16'h6161,
    16'h1871, 16'h0000};

  // Pins: std, sonet, override, aux fail, locked, auto bw, composite en, bits en
  path_cfg_regs path_cfg_regs_inst (
    .STANDARD_SELECT_PIN(pins[0]), .GLOBAL_SONET(pins[1]), .GLOBAL_OVERRIDE(pins[2]),
    .AUX_INPUTS_FAILED(pins[3]), .MAIN_PHASE_LOCKED(pins[4]), .BW_AUTO_SWITCH(pins[5]),
    .COMPOSITE_ENABLE(pins[6]), .BITS_ENABLE(pins[7]), .*
  );

  // Clock at 200 MHz
  always #2.5 CLOCK = ~CLOCK;

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [6:0] a, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: offset %h read %h expected %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    ADDR = a;
    WDATA = d;
    WRITE = 1'b1;
    @(negedge CLOCK);
    WRITE = 1'b0;
    for (int i = 0; i < 7; i++) if (adr[i] == a) mdl[i] = d & msk[i];
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge CLOCK);
    ADDR = a;
    READ = 1'b1;
    @(negedge CLOCK);
    READ = 1'b0;
    chk_flag(RVALID, 1'b1);
    d = RDATA;
  endtask

  function automatic logic [24:0] exp_out(input logic [7:0] a, m, d4, d5, l, q, p);
    logic sq;
    sq = a[6] & p[3];
    return {p[6] & !sq, p[7] & !sq, a[5], (p[2] ? p[1] : a[4]), (a[2:0] != 3'h0 && !m[7]),
      m[7], m[6], (m[2:0] == 3'h1), d4[2:0], d5[2:0], d4[6:4], d5[6:4],
      ((p[5] && !p[4]) ? q[4:0] : l[4:0])};
  endfunction

  task automatic chk_outs;
    logic [7:0] a, m;
    a = mdl[0];
    m = mdl[1];
    repeat (4) @(negedge CLOCK);
    chk({COMPOSITE_CLOCK_OUTPUT_EN, BITS_CLOCK_OUTPUT_EN, COMPOSITE_DUTY_5_8, BITS_SONET,
      AUX_DPLL_RUN, AUX_PHASE_MEASURE, AUX_APLL_FROM_MAIN, MAIN_ANALOG_FEEDBACK, AUX_DAMPING,
      MAIN_DAMPING, AUX_LOWRATE_GAIN, MAIN_LOWRATE_GAIN, MAIN_BANDWIDTH},
      exp_out(a, m, mdl[5], mdl[6], mdl[3], mdl[4], pins));
    chk(AUX_APLL_RATE, m[6] ? path_cfg_pkg::RATE_12E1 + m[5:4] : a[2:0]);
    if (m[2:0] < 3'h6) chk(MAIN_APLL_RATE, m[2:0] < 3'h2 ? 3'h1 : m[2:0]);
    if (mdl[2][1:0] != 2'h3) chk(AUX_BANDWIDTH, mdl[2][1:0]);
  endtask

  task automatic chk_regs;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], d);
      chk_reg(adr[i], d, mdl[i]);
    end
  endtask

  task automatic do_reset;
    RESET = 1'b1;
    repeat (6) @(negedge CLOCK);
    RESET = 1'b0;
    repeat (4) @(negedge CLOCK);
    foreach (mdl[i]) mdl[i] = rst[i];
    mdl[0][4] = pins[0];
    chk_flag(BAD_CODE, 1'b0);
    chk_regs;
    chk_outs;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hD109;
    do_reset;
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      wr(adr[0], 8'(k * 17));
      wr(adr[1], 8'(k * 16 + k % 6));
      chk_outs;
    end
    $display("test code sweep done");
    for (int k = 0; k < 256; k++) begin
      pins = {k[6:0], 1'b1};
      wr(adr[0], {1'b0, k[7], 6'h00});
      chk_outs;
    end
    $display("test pin combos done");
    for (int n = 0; n < 80; n++) begin
      r = $random(seed);
      pins = {r[15:9], 1'b1};
      wr(adr[r[2:0]], r[23:16]);
      rd(adr[r[2:0]], v);
      chk_reg(adr[r[2:0]], v, mdl[r[2:0]]);
      chk_outs;
    end
    $display("test random done");
    foreach (bad[j]) begin
      rd(adr[1], v);
      @(negedge CLOCK);
      wr(adr[bad[j][15:12]], bad[j][11:4]);
      repeat (3) @(negedge CLOCK);
      chk_flag(BAD_CODE, bad[j][0]);
    end
    chk_outs;
    $display("test unused codes done");
    pins[0] = 1'b0;
    do_reset;
    $display("test second reset done");
    summarize;
  end

  // Watchdog at about five times the expected run length
  initial begin
    #60000;
    mismatches++;
    summarize;
  end
endmodule
